//--- dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import wdkc_pkg::*;
;
    localparam int unsigned PRE = 2;
    logic       clk;
    logic       reset_n;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       wd_violation;
    logic       wd_window_open;
    logic       wd_running;
    logic [7:0] d;
    logic [7:0] k;
    int         miscompares;
    int         compares;
    int         seed;
    int         n;
    wdkc_core #(.PRESCALE(PRE)) u_wdkc_core (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .wd_violation, .wd_window_open, .wd_running);
    wdkc_host u_wdkc_host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chkn(input int got, input int exp);
        chk({7'h00, got >= exp - 4 && got <= exp + 4}, 8'h01);
    endtask : chkn
    task automatic complete_run();
        $display("Compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // Cycles spent at one window level, bounded
    task automatic span(input logic lvl, output int c);
        c = 0;
        while (wd_window_open === lvl) begin
            @(posedge clk);
            #1;
            c++;
            if (c > 3000) begin
                miscompares++;
                complete_run();
            end
        end
    endtask : span
    initial begin
        seed = 32'hB512;
        miscompares = 0;
        compares = 0;
        reset_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        reset_n = 1'b1;
        u_wdkc_host.rd(WDKC_ADDR_KEY, d);
        chk(d, WDKC_RST_KEY);
        u_wdkc_host.rd(8'h30, d);
        chk(d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            k = 8'($random(seed));
            u_wdkc_host.wr(WDKC_ADDR_TIMING, k);
            u_wdkc_host.rd(WDKC_ADDR_TIMING, d);
            chk(d, k);
            u_wdkc_host.wr(WDKC_ADDR_KEY, k);
            u_wdkc_host.rd(WDKC_ADDR_KEY, d);
            chk(d, k);
        end
        // Tick four cycles: prescale 2, divider 1
        u_wdkc_host.wr(WDKC_ADDR_TIMING, 8'h12);
        u_wdkc_host.wr(WDKC_ADDR_MODE, 8'h01);
        u_wdkc_host.wr(WDKC_ADDR_STARTUP, 8'h08);
        // Enable lands one edge before the state leaves off
        @(posedge clk);
        #1;
        chk({7'h00, wd_running}, 8'h01);
        span(1'b1, n);
        chkn(n, (2 + 3) * 8 * PRE * 2);
        span(1'b0, n);
        chkn(n, 2 * 8 * PRE * 2);
        span(1'b1, n);
        chkn(n, 3 * 8 * PRE * 2);
        u_wdkc_host.rd(WDKC_ADDR_STATUS, d);
        chk(d & 8'h07, 8'h01);
        span(1'b0, n);
        u_wdkc_host.rd(WDKC_ADDR_KEY, k);
        u_wdkc_host.wr(WDKC_ADDR_KEY, u_wdkc_host.next_key(k));
        chk({6'h00, wd_window_open, wd_violation}, 8'h00);
        span(1'b0, n);
        chkn(n, 2 * 8 * PRE * 2);
        u_wdkc_host.rd(WDKC_ADDR_KEY, d);
        chk(d, u_wdkc_host.next_key(k));
        u_wdkc_host.wr(WDKC_ADDR_KEY, u_wdkc_host.next_key(d) ^ 8'h01);
        chk({7'h00, wd_violation}, 8'h01);
        u_wdkc_host.rd(WDKC_ADDR_STATUS, d);
        chk(d & 8'h06, 8'h04);
        span(1'b1, n);
        // Right key at the wrong time, so only the timing flag may rise
        u_wdkc_host.wr(WDKC_ADDR_KEY, u_wdkc_host.next_key(u_wdkc_host.next_key(k)));
        chk({7'h00, wd_violation}, 8'h01);
        u_wdkc_host.rd(WDKC_ADDR_STATUS, d);
        chk(d & 8'h02, 8'h02);
        u_wdkc_host.wr(WDKC_ADDR_PROTECT, 8'h01);
        u_wdkc_host.wr(WDKC_ADDR_STARTUP, 8'h00);
        u_wdkc_host.rd(WDKC_ADDR_STARTUP, d);
        chk({d[3:0], 3'h0, wd_running}, 8'h81);
        u_wdkc_host.wr(WDKC_ADDR_PROTECT, 8'h00);
        u_wdkc_host.wr(WDKC_ADDR_STARTUP, 8'h00);
        u_wdkc_host.rd(WDKC_ADDR_STATUS, d);
        chk({7'h00, wd_running}, 8'h00);
        u_wdkc_host.wr(WDKC_ADDR_STARTUP, 8'h09);
        @(posedge clk);
        #1;
        span(1'b1, n);
        chkn(n, (2 + 3) * 8 * 3 * PRE * 2);
        u_wdkc_host.wr(WDKC_ADDR_MODE, 8'h41);
        span(1'b0, n);
        u_wdkc_host.rd(WDKC_ADDR_KEY, k);
        u_wdkc_host.wr(WDKC_ADDR_KEY, 8'($random(seed)));
        chk({6'h00, wd_window_open, wd_violation}, 8'h00);
        u_wdkc_host.rd(WDKC_ADDR_KEY, d);
        chk(d, k);
        // Mid-run reset must bring back the idle watchdog and seed key
        reset_n = 1'b0;
        @(posedge clk);
        #1;
        reset_n = 1'b1;
        chk({6'h00, wd_running, wd_window_open}, 8'h00);
        u_wdkc_host.rd(WDKC_ADDR_KEY, d);
        chk(d, WDKC_RST_KEY);
        complete_run();
    end
endmodule : tb_top
bind wdkc_core wdkc_monitor #(.PRESCALE(PRESCALE)) u_wdkc_monitor (.clk, .reset_n, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .wd_violation, .wd_window_open, .wd_running);
`default_nettype wire

//--- dv/wdkc_host.sv
`timescale 1ns/10ps
`default_nettype none
module wdkc_host (
    // Clock
    input  wire logic       clk,
    // Register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'hFF;
        reg_wdata = 8'h00;
    end
    function automatic logic [7:0] next_key(input logic [7:0] k);
        return {k[6:0], k[7] ^ k[5] ^ k[4] ^ k[3]};
    endfunction : next_key
    // Released lines show inverted values so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        @(posedge clk);
        #1;
        {reg_addr, reg_wdata, reg_wr} = {~a, ~v, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1;
        {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge clk);
        #1;
        {reg_addr, reg_rd} = {~a, 1'b0};
        @(posedge clk);
        #1;
        v = reg_rdata;
    endtask : rd
endmodule : wdkc_host
`default_nettype wire

//--- dv/wdkc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module wdkc_monitor
    import wdkc_pkg::*;
#(
    parameter int unsigned PRESCALE = WDKC_PRESCALE_DEF
)(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Register port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // Watchdog state
    input  wire logic       wd_violation,
    input  wire logic       wd_window_open,
    input  wire logic       wd_running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] key_sh;
    logic       sww_sh;
    logic       lock_sh;
    logic       key_wr;
    logic       good;
    function automatic logic [7:0] nk(input logic [7:0] k);
        return {k[6:0], k[7] ^ k[5] ^ k[4] ^ k[3]};
    endfunction : nk
    assign key_wr = reg_wr && reg_addr == WDKC_ADDR_KEY;
    assign good   = reg_wdata == nk(key_sh);
    // Shadow of the registers the properties depend on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            key_sh  <= WDKC_RST_KEY;
            sww_sh  <= WDKC_RST_SWW;
            lock_sh <= WDKC_RST_PROTECT;
        end else begin
            if (key_wr && (!wd_running || (wd_window_open && !sww_sh && good)))
                key_sh <= reg_wdata;
            if (reg_wr && reg_addr == WDKC_ADDR_MODE && !lock_sh)
                sww_sh <= reg_wdata[WDKC_MODE_SWW];
            if (reg_wr && reg_addr == WDKC_ADDR_PROTECT)
                lock_sh <= reg_wdata[WDKC_PROTECT_BIT];
        end
    end
    sequence s_start(logic v);
        reg_wr && reg_addr == WDKC_ADDR_STARTUP && !lock_sh && reg_wdata[WDKC_START_WDON] == v;
    endsequence
    closed_refuse_a: assert property (key_wr && wd_running && !wd_window_open |=> wd_violation)
        else $error("Closed window update not flagged");
    open_update_a: assert property (key_wr && wd_window_open && !sww_sh && good |=>
        !wd_window_open && !wd_violation) else $error("Valid update did not restart");
    key_mismatch_a: assert property (key_wr && wd_window_open && !sww_sh && !good |=>
        wd_violation) else $error("Wrong key not flagged");
    simple_update_a: assert property (key_wr && wd_window_open && sww_sh |=>
        !wd_window_open && !wd_violation) else $error("Simple update did not restart");
    enable_first_a: assert property (s_start(1'b1) ##0 !wd_running |-> ##[1:2]
        wd_running && wd_window_open) else $error("Enable did not open first window");
    disable_stop_a: assert property (s_start(1'b0) |-> ##[1:2] !wd_running)
        else $error("Disable did not stop watchdog");
    locked_hold_a: assert property (lock_sh && reg_wr && reg_addr == WDKC_ADDR_STARTUP
        && wd_running |=> wd_running [*3]) else $error("Locked write took effect");
    key_read_a: assert property (reg_rd && !reg_wr && reg_addr == WDKC_ADDR_KEY |=>
        reg_rdata == $past(key_sh)) else $error("Key readback wrong");
endmodule : wdkc_monitor
`default_nettype wire

//--- pkg/wdkc_pkg.sv
package wdkc_pkg;

    // Register offsets
    localparam logic [7:0] WDKC_ADDR_STATUS  = 8'h26;
    localparam logic [7:0] WDKC_ADDR_MODE    = 8'h27;
    localparam logic [7:0] WDKC_ADDR_TIMING  = 8'h28;
    localparam logic [7:0] WDKC_ADDR_STARTUP = 8'h29;
    localparam logic [7:0] WDKC_ADDR_KEY     = 8'h2A;
    localparam logic [7:0] WDKC_ADDR_PROTECT = 8'h2B;

    // Field positions
    localparam int WDKC_STAT_OPEN   = 3;
    localparam int WDKC_STAT_LFSR   = 2;
    localparam int WDKC_STAT_UV     = 1;
    localparam int WDKC_STAT_EXP    = 0;
    localparam int WDKC_MODE_SWW    = 6;
    localparam int WDKC_START_WDON  = 3;
    localparam int WDKC_PROTECT_BIT = 0;

    // Reset values; factory-programmed in the part, plain defaults here
    localparam logic [7:0] WDKC_RST_TIMING  = 8'h00;
    localparam logic [3:0] WDKC_RST_STARTUP = 4'h0;
    localparam logic [7:0] WDKC_RST_KEY     = 8'h55;
    localparam logic       WDKC_RST_PROTECT = 1'b0;
    localparam logic       WDKC_RST_SWW     = 1'b0;
    localparam logic [5:0] WDKC_RST_DIV     = 6'h00;

    // Timing
    localparam int unsigned WDKC_PRESCALE_DEF = 32;
    localparam logic [11:0] WDKC_WIN_UNIT     = 12'h008;
    localparam logic [11:0] WDKC_ONE          = 12'h001;

    typedef enum logic [1:0] {
        WDKC_ST_OFF    = 2'b00,
        WDKC_ST_FIRST  = 2'b01,
        WDKC_ST_CLOSED = 2'b11,
        WDKC_ST_OPEN   = 2'b10
    } wdkc_state_t;

    typedef struct packed {
        wdkc_state_t state;
        logic [11:0] cnt;
        logic [7:0]  timing;
        logic [3:0]  startup;
        logic [7:0]  key_reg;
        logic        protect_reg;
        logic        simple_window_select;
        logic [5:0]  tick_divider;
        logic        flag_lfsr;
        logic        update_violation_flag;
        logic        flag_expired;
        logic [7:0]  rdata;
        logic        violation;
        logic        window_open;
        logic        running;
    } wdkc_core_t;

    typedef struct packed {
        logic [4:0] pre;
        logic [5:0] div;
        logic       tick;
    } wdkc_tick_t;

endpackage : wdkc_pkg

//--- verilog/wdkc_core.sv
// What this block does
// - Closed portion lasts (closed_len + 1) x 8 ticks, closed_len in timing bits 7:4.
// - Updates during the closed portion are rejected; host must not service then.
// - Open portion lasts (open_len + 1) x 8 ticks, accepts updates.
// - Watchdog runs only while wd_on, bit 3 of startup config, is 1.
// - First open window after reset is (closed + open) x (2 x ext + 1).
// - Holds readable 8-bit key, reset value 0x55.
// - Next key uses LFSR polynomial x^8 + x^6 + x^5 + x^4 + 1.
// - Key step: feedback bit, shift toward MSB, feedback enters LSB.
// - Tick is the clock divided by PRESCALE (32 by default), then by the tick divider + 1.
// - Wrong key in challenge/response mode sets the key mismatch flag.
// - A valid update in the open window refreshes and starts a new period.
// - When locked, only key and protect registers accept writes.
`timescale 1ns/10ps
`default_nettype none
module wdkc_core
    import wdkc_pkg::*;
#(
    parameter int unsigned PRESCALE = WDKC_PRESCALE_DEF
)(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Register port behind the serial interface
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Watchdog state to the reset logic
    output logic            wd_violation,
    output logic            wd_window_open,
    output logic            wd_running
);
    wdkc_core_t s;
    wdkc_core_t n;
    logic        tick;
    logic [7:0]  key_expect;
    logic [11:0] closed_ticks;
    logic [11:0] open_ticks;
    logic [11:0] first_ticks;
    logic [11:0] limit;
    logic        locked;
    logic        wd_on;
    logic        key_wr;
    logic        key_good;

    wdkc_tick #(
        .PRESCALE (PRESCALE)
    ) u_tick (
        .clk     (clk),
        .reset_n (reset_n),
        .divider (s.tick_divider),
        .tick    (tick)
    );

    wdkc_lfsr u_lfsr (
        .key_now  (s.key_reg),
        .key_next (key_expect)
    );

    // Window lengths in ticks; worst case 3840 fits in 12 bits
    always_comb begin
        closed_ticks = (12'(s.timing[7:4]) + WDKC_ONE) * WDKC_WIN_UNIT;
        open_ticks   = (12'(s.timing[3:0]) + WDKC_ONE) * WDKC_WIN_UNIT;
        first_ticks  = (closed_ticks + open_ticks)
                     * ((12'(s.startup[2:0]) << 1) + WDKC_ONE);
        case (s.state)
            WDKC_ST_CLOSED: limit = closed_ticks;
            WDKC_ST_OPEN:   limit = open_ticks;
            WDKC_ST_FIRST:  limit = first_ticks;
            default:        limit = closed_ticks;
        endcase
    end

    always_comb begin
        locked   = s.protect_reg;
        wd_on    = s.startup[WDKC_START_WDON];
        key_wr   = reg_wr && (reg_addr == WDKC_ADDR_KEY);
        key_good = s.simple_window_select || (reg_wdata == key_expect);
    end

    always_comb begin
        n           = s;
        n.violation = 1'b0;

        // Reads; status clears on read, events below still win
        if (reg_rd) begin
            case (reg_addr)
                WDKC_ADDR_STATUS: begin
                    n.rdata = '0;
                    n.rdata[WDKC_STAT_OPEN] = s.window_open;
                    n.rdata[WDKC_STAT_LFSR] = s.flag_lfsr;
                    n.rdata[WDKC_STAT_UV]   = s.update_violation_flag;
                    n.rdata[WDKC_STAT_EXP]  = s.flag_expired;
                    n.flag_lfsr             = 1'b0;
                    n.update_violation_flag = 1'b0;
                    n.flag_expired          = 1'b0;
                end
                WDKC_ADDR_MODE: begin
                    n.rdata = '0;
                    n.rdata[WDKC_MODE_SWW] = s.simple_window_select;
                    n.rdata[5:0]           = s.tick_divider;
                end
                WDKC_ADDR_TIMING:  n.rdata = s.timing;
                WDKC_ADDR_STARTUP: n.rdata = {4'h0, s.startup};
                WDKC_ADDR_KEY:     n.rdata = s.key_reg;
                WDKC_ADDR_PROTECT: n.rdata = {7'h00, s.protect_reg};
                default:           n.rdata = 8'h00;
            endcase
        end

        // Configuration writes
        if (reg_wr) begin
            case (reg_addr)
                WDKC_ADDR_MODE: begin
                    if (!locked) begin
                        n.simple_window_select = reg_wdata[WDKC_MODE_SWW];
                        n.tick_divider         = reg_wdata[5:0];
                    end
                end
                WDKC_ADDR_TIMING: begin
                    if (!locked) begin
                        n.timing = reg_wdata;
                    end
                end
                WDKC_ADDR_STARTUP: begin
                    if (!locked) begin
                        n.startup = reg_wdata[3:0];
                    end
                end
                WDKC_ADDR_PROTECT: n.protect_reg = reg_wdata[WDKC_PROTECT_BIT];
                default: ;
            endcase
        end

        // Window timer
        case (s.state)
            WDKC_ST_OFF: begin
                n.cnt = '0;
                if (wd_on) begin
                    n.state = WDKC_ST_FIRST;
                end
            end
            WDKC_ST_FIRST, WDKC_ST_CLOSED, WDKC_ST_OPEN: begin
                if (!wd_on) begin
                    n.state = WDKC_ST_OFF;
                    n.cnt   = '0;
                end else if (tick) begin
                    if (s.cnt + WDKC_ONE >= limit) begin
                        n.cnt = '0;
                        if (s.state == WDKC_ST_CLOSED) begin
                            n.state = WDKC_ST_OPEN;
                        end else begin
                            // Open window ran out with no update
                            n.flag_expired = 1'b1;
                            n.violation    = 1'b1;
                            n.state        = WDKC_ST_CLOSED;
                        end
                    end else begin
                        n.cnt = s.cnt + WDKC_ONE;
                    end
                end
            end
            default: begin
                n.state = WDKC_ST_OFF;
                n.cnt   = '0;
            end
        endcase

        // Watchdog updates through the key register, allowed when locked
        if (key_wr) begin
            if (s.state == WDKC_ST_OFF || !wd_on) begin
                // Idle watchdog: key may be seeded freely
                n.key_reg = reg_wdata;
            end else if (!key_good) begin
                n.flag_lfsr = 1'b1;
                n.violation = 1'b1;
            end else if (s.state == WDKC_ST_CLOSED) begin
                n.update_violation_flag = 1'b1;
                n.violation             = 1'b1;
            end else begin
                n.state = WDKC_ST_CLOSED;
                n.cnt   = '0;
                if (!s.simple_window_select) begin
                    n.key_reg = reg_wdata;
                end
            end
        end

        n.window_open = (n.state == WDKC_ST_FIRST) || (n.state == WDKC_ST_OPEN);
        n.running     = (n.state != WDKC_ST_OFF);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s                       <= '0;
            s.state                 <= WDKC_ST_OFF;
            s.timing                <= WDKC_RST_TIMING;
            s.startup               <= WDKC_RST_STARTUP;
            s.key_reg               <= WDKC_RST_KEY;
            s.protect_reg           <= WDKC_RST_PROTECT;
            s.simple_window_select  <= WDKC_RST_SWW;
            s.tick_divider          <= WDKC_RST_DIV;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata      = s.rdata;
    assign wd_violation   = s.violation;
    assign wd_window_open = s.window_open;
    assign wd_running     = s.running;
endmodule : wdkc_core
`default_nettype wire

//--- verilog/wdkc_lfsr.sv
`timescale 1ns/10ps
`default_nettype none
module wdkc_lfsr
    import wdkc_pkg::*;
(
    // Current key in, next key out
    input  wire logic [7:0] key_now,
    output logic      [7:0] key_next
);
    logic fb;

    always_comb begin
        fb       = key_now[7] ^ key_now[5] ^ key_now[4] ^ key_now[3];
        key_next = {key_now[6:0], fb};
    end
endmodule : wdkc_lfsr
`default_nettype wire

//--- verilog/wdkc_tick.sv
`timescale 1ns/10ps
`default_nettype none
module wdkc_tick
    import wdkc_pkg::*;
#(
    parameter int unsigned PRESCALE = WDKC_PRESCALE_DEF
)(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Divider setting and tick pulse
    input  wire logic [5:0] divider,
    output logic            tick
);
    wdkc_tick_t s;
    wdkc_tick_t n;

    // Five-bit prescaler cannot count past 32
    if (PRESCALE < 2 || PRESCALE > 32) begin : g_bad_prescale
        $error("PRESCALE must lie in 2..32");
    end

    localparam logic [4:0] PRE_LAST = 5'(PRESCALE - 1);

    always_comb begin
        n      = s;
        n.tick = 1'b0;
        if (s.pre == PRE_LAST) begin
            n.pre = '0;
            // Second stage divides by divider + 1
            if (s.div >= divider) begin
                n.div  = '0;
                n.tick = 1'b1;
            end else begin
                n.div = s.div + 6'h01;
            end
        end else begin
            n.pre = s.pre + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;
endmodule : wdkc_tick
`default_nettype wire
